// ---- inc/eips_pkg.sv ----
// Constants and types shared by the encoder position set-up block
`default_nettype none
package eips_pkg;
    // Register byte offsets
    localparam logic [7:0] EIPS_SEL = 8'h00;
    localparam logic [7:0] EIPS_LINES = 8'h04;
    localparam logic [7:0] EIPS_TOP = 8'h08;
    localparam logic [7:0] EIPS_BOT = 8'h0C;
    localparam logic [7:0] EIPS_HOME = 8'h10;
    localparam logic [7:0] EIPS_MODE = 8'h14;
    localparam logic [7:0] EIPS_SSI = 8'h18;
    localparam logic [7:0] EIPS_BITS = 8'h1C;
    localparam logic [7:0] EIPS_SPEED = 8'h20;
    localparam logic [7:0] EIPS_LIMIT = 8'h24;
    localparam logic [7:0] EIPS_ACT = 8'h28;
    localparam logic [7:0] EIPS_REF = 8'h2C;
    localparam logic [7:0] EIPS_STAT = 8'h30;
    localparam logic [7:0] EIPS_FREQ = 8'h34;
    localparam logic [7:0] EIPS_SSEL = 8'h38;
    localparam logic [7:0] EIPS_SCOPE = 8'h3C;
    localparam logic [7:0] EIPS_IST = 8'h40;
    localparam logic [7:0] EIPS_IMASK = 8'h44;
    // Reset values and limits
    localparam logic [13:0] EIPS_LINES_RST = 14'h0400;
    localparam logic [31:0] EIPS_LINES_MAX = 32'h00002000;
    localparam logic [15:0] EIPS_RATIO_RST = 16'h0001;
    localparam logic [31:0] EIPS_HOME_RST = 32'h00000000;
    localparam logic [7:0] EIPS_MODE_NOREF = 8'h0A;
    // Decimal digit weights of the selector
    localparam logic [13:0] EIPS_K1000 = 14'h03E8;
    localparam logic [13:0] EIPS_K100 = 14'h0064;
    localparam logic [13:0] EIPS_K10 = 14'h000A;
    // Protocol digit
    localparam logic [3:0] EIPS_PR_SINCOS = 4'h0;
    localparam logic [3:0] EIPS_PR_BIDIR = 4'h1;
    localparam logic [3:0] EIPS_PR_HALF = 4'h3;
    localparam logic [3:0] EIPS_PR_SSIG = 4'h5;
    localparam logic [3:0] EIPS_PR_SSIB = 4'h6;
    // Incremental track digit
    localparam logic [3:0] EIPS_TR_NONE = 4'h0;
    localparam logic [3:0] EIPS_TR_SINCOS = 4'h1;
    localparam logic [3:0] EIPS_TR_SQ = 4'h8;
    localparam logic [3:0] EIPS_TR_SQR = 4'h9;
    // Rate field, two lowest decimal digits
    localparam logic [6:0] EIPS_RT_100 = 7'h01;
    localparam logic [6:0] EIPS_RT_250 = 7'h02;
    localparam logic [6:0] EIPS_RT_500 = 7'h05;
    localparam logic [6:0] EIPS_RT_1000 = 7'h0A;
    localparam logic [6:0] EIPS_RT_9K6 = 7'h09;
    localparam logic [6:0] EIPS_RT_19K2 = 7'h13;
    localparam logic [6:0] EIPS_RT_38K4 = 7'h26;
    // Interrupt bit positions
    localparam int EIPS_IRQ_REF = 0;
    localparam int EIPS_IRQ_JUMP = 1;
    localparam int EIPS_IRQ_CFG = 2;
    localparam int EIPS_IRQ_HOME = 3;
    // Divider step count
    localparam logic [5:0] EIPS_DIV_STEPS = 6'h30;
    typedef enum logic [1:0] {
        EIPS_IDLE = 2'b00,
        EIPS_DIV = 2'b01,
        EIPS_FIN = 2'b10
    } eips_dst_t;
endpackage : eips_pkg
`default_nettype wire

// ---- inc/eips_if.sv ----
// Link between the register block and the gear scaling unit
`timescale 1ns/1ps
`default_nettype none
interface eips_if;
    logic start;
    logic [31:0] raw;
    logic [15:0] top;
    logic [15:0] bottom;
    logic [31:0] home;
    logic busy;
    logic done;
    logic [31:0] pos;
    modport ctl (output start, raw, top, bottom, home,
                 input busy, done, pos);
    modport calc (input start, raw, top, bottom, home,
                  output busy, done, pos);
endinterface : eips_if
`default_nettype wire

// ---- hdl/eips_pos.sv ----
// Sequential gear scaling of the raw encoder count
`timescale 1ns/1ps
`default_nettype none
module eips_pos (
    input wire logic core_clk,
    input wire logic rstn,
    eips_if.calc bus
);
    typedef struct packed {
        eips_pkg::eips_dst_t st;
        logic [5:0] cnt;
        logic [16:0] rem;
        logic [47:0] quo;
        logic neg;
        logic [31:0] pos;
        logic done;
    } eips_pos_t;
    eips_pos_t s;
    eips_pos_t next_s;
    logic signed [47:0] prod;
    logic [16:0] trial;
    logic [16:0] div;
    logic [31:0] scaled;

    // Signed product, ratio top sign sets the count direction
    assign prod = $signed(bus.raw) * $signed(bus.top);
    // Zero bottom would hang the divider, treat it as one
    assign div = {1'b0, (bus.bottom == 16'h0000) ? 16'h0001 : bus.bottom};
    assign trial = {s.rem[15:0], s.quo[47]};
    assign scaled = s.neg ? (~s.quo[31:0] + 32'h00000001) : s.quo[31:0];
    assign bus.busy = (s.st != eips_pkg::EIPS_IDLE);
    assign bus.done = s.done;
    assign bus.pos = s.pos;

    // Restoring division, one quotient bit per clock
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        case (s.st)
            eips_pkg::EIPS_IDLE:
            begin
                if (bus.start)
                begin
                    next_s.neg = prod[47];
                    next_s.quo = prod[47] ? 48'(-prod) : 48'(prod);
                    next_s.rem = 17'h00000;
                    next_s.cnt = eips_pkg::EIPS_DIV_STEPS;
                    next_s.st = eips_pkg::EIPS_DIV;
                end
            end
            eips_pkg::EIPS_DIV:
            begin
                next_s.rem = (trial >= div) ? trial - div : trial;
                next_s.quo = {s.quo[46:0], trial >= div};
                next_s.cnt = s.cnt - 6'h01;
                if (s.cnt == 6'h01)
                    next_s.st = eips_pkg::EIPS_FIN;
            end
            eips_pkg::EIPS_FIN:
            begin
                next_s.pos = scaled + bus.home;
                next_s.done = 1'b1;
                next_s.st = eips_pkg::EIPS_IDLE;
            end
            default: next_s.st = eips_pkg::EIPS_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_div_latency: assert property (
        (bus.start && !bus.busy) |-> ##50 bus.done)
        else $error("scaling did not finish in 50 cycles");
    // Sign is judged from raw count and ratio top, not from the quotient
    a_dir_sign: assert property (
        (s.st == eips_pkg::EIPS_IDLE && bus.start && bus.raw != 32'h0 &&
         bus.top != 16'h0) |=>
        (s.neg == ($past(bus.raw[31]) ^ $past(bus.top[15]))))
        else $error("scaled count sign does not follow ratio sign");
endmodule : eips_pos
`default_nettype wire

// ---- hdl/eips_top.sv ----
// Encoder input position set-up: APB registers, decode, position
//
// Contract
// - Motion start loads reference with actual position
// - Negative ratio top reverses counting direction
// - Ratio change forces position recompute
// - Home offset resets to zero, added
// - Absolute encoder, mode 10 needs no homing
// - Line count 0 to 8192, default 1024
// - SSI uses line count only with tracks
// - Bidirectional protocol allows only 100 kBit/s
// - Two low digits select data rate
// - Hundreds digit selects incremental track
// - Thousands digit selects protocol
// - Parameters foreign to family have no effect
// - Controller output added onto speed reference
// - Zero limit disables controller correction
// - Scope pairs scaled by 1, 10, 100 or 1000, overflow harmless
`timescale 1ns/1ps
`default_nettype none
module eips_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] enc_raw,
    input wire logic ctrl_tick,
    input wire logic motion_start,
    input wire logic home_done,
    input wire logic [31:0] pc_out,
    output logic [31:0] freq_cmd,
    output logic [31:0] act_pos,
    output logic [13:0] line_count,
    output logic [15:0] ssi_interval,
    output logic [15:0] ssi_err_bits,
    output logic homing_req,
    output logic irq
);
    typedef struct packed {
        logic [13:0] sel;
        logic [13:0] lines;
        logic [15:0] top;
        logic [15:0] bot;
        logic [31:0] home;
        logic [7:0] mode;
        logic [31:0] ssi;
        logic [5:0] turn;
        logic [5:0] multi;
        logic [31:0] speed;
        logic [31:0] limit;
        logic [31:0] act;
        logic [31:0] ref_pos;
        logic [31:0] freq;
        logic [1:0] ssel;
        logic [3:0] ist;
        logic [3:0] imask;
        logic [31:0] rdata;
        logic err;
        logic pend;
        logic jump;
        logic homed;
        logic init;
        logic start;
        logic cfgq;
    } eips_top_t;
    eips_top_t s;
    eips_top_t next_s;

    logic [3:0] prot;
    logic [3:0] track;
    logic [6:0] rate;
    logic is_ssi;
    logic is_abs;
    logic bits_used;
    logic lines_on;
    logic rate_ok;
    logic cfg_err;
    logic noref;
    logic setup;
    logic acc;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic [3:0] clr;
    logic [3:0] set;
    logic [6:0] total;
    logic [31:0] raw_eff;
    logic signed [31:0] corr;
    logic signed [31:0] lim;
    logic signed [31:0] pcs;
    logic start_now;

    eips_if pbus ();

    eips_pos u_pos (
        .core_clk(core_clk),
        .rstn(rstn),
        .bus(pbus)
    );

    // Scope view: low half word of position times 1, 10, 100, 1000
    function automatic logic [15:0] eips_scale(input logic [31:0] v,
                                               input logic [1:0] k);
        logic [31:0] r;
        case (k)
            2'h1: r = v * 32'h0000000A;
            2'h2: r = v * 32'h00000064;
            2'h3: r = v * 32'h000003E8;
            default: r = v;
        endcase
        return r[15:0];
    endfunction : eips_scale

    // Selector digits: protocol, track, rate
    assign prot = 4'(s.sel / eips_pkg::EIPS_K1000);
    assign track = 4'((s.sel / eips_pkg::EIPS_K100) % eips_pkg::EIPS_K10);
    assign rate = 7'(s.sel % eips_pkg::EIPS_K100);
    assign is_ssi = (prot == eips_pkg::EIPS_PR_SSIG) ||
                    (prot == eips_pkg::EIPS_PR_SSIB);
    assign is_abs = (prot != eips_pkg::EIPS_PR_SINCOS);
    // Turn and multiturn widths only mean something for these families
    assign bits_used = is_ssi || (prot == eips_pkg::EIPS_PR_HALF);
    assign noref = is_abs && (s.mode == eips_pkg::EIPS_MODE_NOREF);

    // Line count is live for SSI only with track 1 or 9, otherwise with any track or absolute
    always_comb
    begin
        if (is_ssi)
            lines_on = (track == eips_pkg::EIPS_TR_SINCOS) ||
                       (track == eips_pkg::EIPS_TR_SQR);
        else
            lines_on = (track != eips_pkg::EIPS_TR_NONE) || is_abs;
    end

    // Allowed rate per protocol
    always_comb
    begin
        case (prot)
            eips_pkg::EIPS_PR_SINCOS: rate_ok = (rate == 7'h00);
            eips_pkg::EIPS_PR_BIDIR: rate_ok = (rate == eips_pkg::EIPS_RT_100);
            eips_pkg::EIPS_PR_HALF: rate_ok = (rate == eips_pkg::EIPS_RT_9K6) ||
                                       (rate == eips_pkg::EIPS_RT_19K2) ||
                                       (rate == eips_pkg::EIPS_RT_38K4);
            eips_pkg::EIPS_PR_SSIG,
            eips_pkg::EIPS_PR_SSIB: rate_ok = (rate == eips_pkg::EIPS_RT_100) ||
                                       (rate == eips_pkg::EIPS_RT_250) ||
                                       (rate == eips_pkg::EIPS_RT_500) ||
                                       (rate == eips_pkg::EIPS_RT_1000);
            default: rate_ok = 1'b0;
        endcase
    end
    assign cfg_err = !rate_ok || !((track == eips_pkg::EIPS_TR_NONE) ||
                     (track == eips_pkg::EIPS_TR_SINCOS) ||
                     (track == eips_pkg::EIPS_TR_SQ) ||
                     (track == eips_pkg::EIPS_TR_SQR));

    // Absolute word trimmed to turn plus multiturn bits
    assign total = 7'(s.turn) + 7'(s.multi);
    assign raw_eff = (bits_used && total < 7'h20) ?
                     (enc_raw & ((32'h00000001 << total) - 32'h00000001)) :
                     enc_raw;

    // Controller correction clamp; a zero limit switches it off
    assign lim = $signed(s.limit);
    assign pcs = $signed(pc_out);
    always_comb
    begin
        if (s.limit == 32'h00000000)
            corr = 32'sh00000000;
        else if (pcs > lim)
            corr = lim;
        else if (pcs < -lim)
            corr = -lim;
        else
            corr = pcs;
    end

    // APB phases; zero wait states, data captured at setup
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr = acc && pwrite && !s.err;
    assign pready = 1'b1;
    assign pslverr = acc && s.err;
    assign prdata = s.rdata;

    // Address decode and read mux
    always_comb
    begin
        hit = 1'b1;
        rd = 32'h00000000;
        case (paddr)
            eips_pkg::EIPS_SEL: rd = {18'h00000, s.sel};
            eips_pkg::EIPS_LINES: rd = {18'h00000, s.lines};
            eips_pkg::EIPS_TOP: rd = {{16{s.top[15]}}, s.top};
            eips_pkg::EIPS_BOT: rd = {16'h0000, s.bot};
            eips_pkg::EIPS_HOME: rd = s.home;
            eips_pkg::EIPS_MODE: rd = {24'h000000, s.mode};
            eips_pkg::EIPS_SSI: rd = s.ssi;
            eips_pkg::EIPS_BITS: rd = {18'h00000, s.multi, 2'h0, s.turn};
            eips_pkg::EIPS_SPEED: rd = s.speed;
            eips_pkg::EIPS_LIMIT: rd = s.limit;
            eips_pkg::EIPS_ACT: rd = s.act;
            eips_pkg::EIPS_REF: rd = s.ref_pos;
            eips_pkg::EIPS_STAT: rd = {10'h000, pbus.busy, s.homed, is_abs,
                                       is_ssi, lines_on, cfg_err, 1'b0,
                                       rate, track, prot};
            eips_pkg::EIPS_FREQ: rd = s.freq;
            eips_pkg::EIPS_SSEL: rd = {30'h00000000, s.ssel};
            eips_pkg::EIPS_SCOPE: rd = {eips_scale(s.ref_pos, s.ssel),
                                        eips_scale(s.act, s.ssel)};
            eips_pkg::EIPS_IST: rd = {28'h0000000, s.ist};
            eips_pkg::EIPS_IMASK: rd = {28'h0000000, s.imask};
            default: hit = 1'b0;
        endcase
    end

    // Recompute trigger: control tick or pending ratio change
    assign start_now = !s.start && !pbus.busy && (ctrl_tick || s.pend);
    assign pbus.start = s.start;
    assign pbus.raw = raw_eff;
    assign pbus.top = s.top;
    assign pbus.bottom = s.bot;
    assign pbus.home = s.home;

    // Next-state logic
    always_comb
    begin
        next_s = s;
        clr = 4'h0;
        set = 4'h0;
        if (setup)
        begin
            next_s.rdata = hit ? rd : 32'h00000000;
            // Out-of-range line count is refused, value kept
            next_s.err = !hit || (pwrite && paddr == eips_pkg::EIPS_LINES &&
                         pwdata > eips_pkg::EIPS_LINES_MAX);
        end
        if (wr)
        begin
            case (paddr)
                eips_pkg::EIPS_SEL: next_s.sel = pwdata[13:0];
                eips_pkg::EIPS_LINES: next_s.lines = pwdata[13:0];
                eips_pkg::EIPS_TOP: next_s.top = pwdata[15:0];
                eips_pkg::EIPS_BOT: next_s.bot = pwdata[15:0];
                eips_pkg::EIPS_HOME: next_s.home = pwdata;
                eips_pkg::EIPS_MODE: next_s.mode = pwdata[7:0];
                eips_pkg::EIPS_SSI: next_s.ssi = pwdata;
                eips_pkg::EIPS_BITS:
                begin
                    next_s.turn = pwdata[5:0];
                    next_s.multi = pwdata[13:8];
                end
                eips_pkg::EIPS_SPEED: next_s.speed = pwdata;
                eips_pkg::EIPS_LIMIT: next_s.limit = pwdata;
                eips_pkg::EIPS_SSEL: next_s.ssel = pwdata[1:0];
                eips_pkg::EIPS_IST: clr = pwdata[3:0];
                eips_pkg::EIPS_IMASK: next_s.imask = pwdata[3:0];
                default: next_s.ssel = s.ssel;
            endcase
        end
        // Ratio edits force a fresh scaling, position may jump
        next_s.start = start_now;
        if (start_now)
            next_s.jump = s.pend;
        next_s.pend = (s.pend && !start_now) || (wr &&
                      (paddr == eips_pkg::EIPS_TOP ||
                       paddr == eips_pkg::EIPS_BOT));
        if (pbus.done)
        begin
            next_s.act = pbus.pos;
            next_s.init = 1'b1;
            set[eips_pkg::EIPS_IRQ_JUMP] = s.jump;
        end
        // Reference follows actual at every motion start
        if (motion_start)
        begin
            next_s.ref_pos = s.act;
            set[eips_pkg::EIPS_IRQ_REF] = 1'b1;
        end
        // Absolute encoder in no-referencing mode counts as homed
        if (!s.homed && ((noref && s.init) || home_done))
        begin
            next_s.homed = 1'b1;
            set[eips_pkg::EIPS_IRQ_HOME] = 1'b1;
        end
        next_s.cfgq = cfg_err;
        set[eips_pkg::EIPS_IRQ_CFG] = cfg_err && !s.cfgq;
        // Speed reference plus clamped controller output
        next_s.freq = s.speed + 32'(corr);
        // Set beats clear so no event is lost
        next_s.ist = (s.ist & ~clr) | set;
    end

    // State register with reset values
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.lines <= eips_pkg::EIPS_LINES_RST;
            s.top <= eips_pkg::EIPS_RATIO_RST;
            s.bot <= eips_pkg::EIPS_RATIO_RST;
            s.home <= eips_pkg::EIPS_HOME_RST;
        end
        else
            s <= next_s;
    end

    // Outputs; foreign SSI settings are held at zero
    assign freq_cmd = s.freq;
    assign act_pos = s.act;
    assign line_count = lines_on ? s.lines : 14'h0000;
    assign ssi_interval = is_ssi ? s.ssi[15:0] : 16'h0000;
    assign ssi_err_bits = is_ssi ? s.ssi[31:16] : 16'h0000;
    assign homing_req = !s.homed && !noref;
    assign irq = |(s.ist & s.imask);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    sequence s_top_wr;
        psel && penable && pwrite && !s.err &&
        paddr == eips_pkg::EIPS_TOP;
    endsequence
    sequence s_recalc;
        ##[1:120] pbus.done;
    endsequence

    a_ref_load: assert property (motion_start |=> s.ref_pos == $past(s.act))
        else $error("reference not loaded from actual position");
    a_ratio_recalc: assert property (s_top_wr |-> s_recalc)
        else $error("ratio change not followed by recompute");
    a_home_reset: assert property ($rose(rstn) |-> s.home == 32'h0)
        else $error("home offset not zero after reset");
    a_noref_home: assert property ((noref && s.init) |=> !homing_req)
        else $error("homing requested in no-referencing mode");
    a_lines_range: assert property (s.lines <= 14'h2000)
        else $error("line count above 8192");
    a_lines_gate: assert property ((is_ssi && track == 4'h0) |-> line_count == 14'h0)
        else $error("line count live for SSI without tracks");
    a_rate_fixed: assert property ((prot == 4'h1 && rate != 7'h01) |-> cfg_err)
        else $error("bidirectional protocol accepted other rate");
    a_ssi_gate: assert property (!is_ssi |-> (ssi_interval == 16'h0 && ssi_err_bits == 16'h0))
        else $error("SSI settings leak to non-SSI encoder");
    a_freq_clamp: assert property ((s.limit != 32'h0 && pcs > lim) |=> s.freq == $past(s.speed + s.limit))
        else $error("correction not clamped to limit");
    a_freq_off: assert property ((s.limit == 32'h0) |=> s.freq == $past(s.speed))
        else $error("zero limit did not disable correction");
endmodule : eips_top
`default_nettype wire

// ---- testbench/eips_enc.sv ----
// Encoder model: raw count that advances by one each clock while step is high
`timescale 1ns/1ps
`default_nettype none
module eips_enc (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic step,
    output logic [31:0] enc_raw
);
    // Count only moves when stepped, so the bench knows it exactly
    // Motor encoder use: third ratio kept one to one, one count a step
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            enc_raw <= 32'h00000000;
        else if (step)
            enc_raw <= enc_raw + 32'h00000001;
    end
endmodule : eips_enc
`default_nettype wire

// ---- testbench/eips_top_tb.sv ----
// Self-checking bench for the encoder position set-up block
`timescale 1ns/1ps
`default_nettype none
module eips_top_tb;
    logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
    logic ctrl_tick, motion_start, home_done, homing_req, step, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, enc_raw, pc_out, freq_cmd, act_pos, rdv;
    logic [13:0] line_count;
    logic [15:0] ssi_interval, ssi_err_bits;
    int error_cnt = 0;
    int n_checks = 0;
    eips_enc enc (.core_clk(core_clk), .rstn(rstn), .step(step),
        .enc_raw(enc_raw));
    eips_top uut (.core_clk(core_clk), .rstn(rstn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .enc_raw(enc_raw), .ctrl_tick(ctrl_tick),
        .motion_start(motion_start), .home_done(home_done),
        .pc_out(pc_out), .freq_cmd(freq_cmd), .act_pos(act_pos),
        .line_count(line_count), .ssi_interval(ssi_interval),
        .ssi_err_bits(ssi_err_bits), .homing_req(homing_req), .irq(irq));
    // Free-running 50 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] wd);
        @(posedge core_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rdv = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h00000000);
        chk($sformatf("reg %h", a), rdv, e);
    endtask : rc
    // Strobe select: 0 step, 1 tick, 2 motion start, 3 home done
    task automatic pulse(input int w, input int n);
        @(posedge core_clk);
        case (w)
            0: step <= 1'b1;
            1: ctrl_tick <= 1'b1;
            2: motion_start <= 1'b1;
            default: home_done <= 1'b1;
        endcase
        repeat (n) @(posedge core_clk);
        {step, ctrl_tick, motion_start, home_done} <= 4'h0;
        repeat (3) @(posedge core_clk);
    endtask : pulse
    task automatic t_regs;
        rc(eips_pkg::EIPS_LINES, 32'h00000400);
        rc(eips_pkg::EIPS_HOME, 32'h00000000);
        chk("homing", homing_req, 1'b1);
        rc(8'h48, 32'h00000000);
        chk("unmapped err", rerr, 1'b1);
        wr(eips_pkg::EIPS_LINES, 32'h00002001);
        chk("lines err", rerr, 1'b1);
        rc(eips_pkg::EIPS_LINES, 32'h00000400);
        wr(eips_pkg::EIPS_LINES, 32'h00002000);
        rc(eips_pkg::EIPS_LINES, 32'h00002000);
    endtask : t_regs
    // Selector digits, line gating and SSI-only outputs
    task automatic t_decode;
        int codes [8] = '{0, 900, 1101, 1102, 3119, 5001, 5111, 6910};
        int p, t, r;
        logic bad, lon, ssi;
        wr(eips_pkg::EIPS_SSI, 32'h00070003);
        foreach (codes[i])
        begin
            p = codes[i] / 1000;
            t = (codes[i] / 100) % 10;
            r = codes[i] % 100;
            ssi = p == 5 || p == 6;
            bad = !(t inside {0, 1, 8, 9});
            if (p == 0) bad |= r != 0;
            else if (p == 1) bad |= r != 1;
            else if (p == 3) bad |= !(r inside {9, 19, 38});
            else if (ssi) bad |= !(r inside {1, 2, 5, 10});
            else bad = 1'b1;
            // SSI needs track 1 or 9; other absolute types always count
            lon = ssi ? (t == 1 || t == 9) : (t != 0 || p != 0);
            wr(eips_pkg::EIPS_SEL, codes[i]);
            repeat (2) @(posedge core_clk);
            xfer(eips_pkg::EIPS_STAT, 1'b0, 32'h00000000);
            chk("stat", rdv & 32'h00037FFF, {14'h0, lon, bad, 1'b0,
                7'(r), 4'(t), 4'(p)});
            chk("lines", line_count, lon ? 14'h2000 : 14'h0000);
            chk("ssi", {ssi_err_bits, ssi_interval},
                ssi ? 32'h00070003 : 32'h00000000);
            if (codes[i] == 1102)
            begin
                xfer(eips_pkg::EIPS_IST, 1'b0, 32'h00000000);
                chk("cfg irq", rdv & 32'h00000004, 32'h00000004);
            end
        end
    endtask : t_decode
    task automatic t_pos;
        wr(eips_pkg::EIPS_SEL, 32'h00000000);
        pulse(0, 10);
        wr(eips_pkg::EIPS_TOP, 32'h00000003);
        wr(eips_pkg::EIPS_BOT, 32'h00000002);
        wr(eips_pkg::EIPS_HOME, 32'h00000005);
        pulse(1, 1);
        repeat (60) @(posedge core_clk);
        chk("act", act_pos, 32'h00000014);
        wr(eips_pkg::EIPS_IST, 32'hFFFFFFFF);
        wr(eips_pkg::EIPS_TOP, 32'h0000FFFD);
        repeat (120) @(posedge core_clk);
        chk("act neg", act_pos, 32'hFFFFFFF6);
        xfer(eips_pkg::EIPS_IST, 1'b0, 32'h00000000);
        chk("jump irq", rdv & 32'h00000002, 32'h00000002);
    endtask : t_pos
    // Reference load, interrupt mask and clear, scope scaling
    task automatic t_motion;
        wr(eips_pkg::EIPS_IMASK, 32'h00000000);
        wr(eips_pkg::EIPS_IST, 32'hFFFFFFFF);
        pulse(2, 1);
        rc(eips_pkg::EIPS_REF, 32'hFFFFFFF6);
        chk("irq masked", irq, 1'b0);
        wr(eips_pkg::EIPS_IMASK, 32'h00000001);
        @(posedge core_clk);
        chk("irq on", irq, 1'b1);
        wr(eips_pkg::EIPS_IST, 32'h00000001);
        @(posedge core_clk);
        chk("irq clr", irq, 1'b0);
        rc(eips_pkg::EIPS_SCOPE, 32'hFFF6FFF6);
        wr(eips_pkg::EIPS_SSEL, 32'h00000001);
        rc(eips_pkg::EIPS_SCOPE, 32'hFF9CFF9C);
    endtask : t_motion
    // Homing run first; homed is sticky, so a reset precedes mode 10
    task automatic t_home;
        wr(eips_pkg::EIPS_SEL, 32'h000013ED);
        @(posedge core_clk);
        chk("homing", homing_req, 1'b1);
        pulse(3, 1);
        chk("homed", homing_req, 1'b0);
        rc(eips_pkg::EIPS_IST, 32'h00000008);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        wr(eips_pkg::EIPS_SEL, 32'h000013ED);
        wr(eips_pkg::EIPS_MODE, 32'h0000000A);
        @(posedge core_clk);
        chk("no homing", homing_req, 1'b0);
        // Two turn bits plus one multiturn bit keep count bits 2:0
        wr(eips_pkg::EIPS_BITS, 32'h00000102);
        pulse(0, 10);
        pulse(1, 1);
        repeat (60) @(posedge core_clk);
        chk("masked act", act_pos, 32'h00000002);
        xfer(eips_pkg::EIPS_STAT, 1'b0, 32'h00000000);
        chk("noref homed", rdv[20], 1'b1);
    endtask : t_home
    task automatic t_freq;
        logic [31:0] pcs [3] = '{32'h000000C8, 32'hFFFFFF38, 32'h00000032};
        logic [31:0] exps [3] = '{32'h0000044C, 32'h00000384, 32'h0000041A};
        wr(eips_pkg::EIPS_SPEED, 32'h000003E8);
        wr(eips_pkg::EIPS_LIMIT, 32'h00000064);
        foreach (pcs[i])
        begin
            pc_out <= pcs[i];
            repeat (4) @(posedge core_clk);
            chk("freq", freq_cmd, exps[i]);
        end
        wr(eips_pkg::EIPS_LIMIT, 32'h00000000);
        repeat (4) @(posedge core_clk);
        chk("freq off", freq_cmd, 32'h000003E8);
    endtask : t_freq
    // Hang guard
    initial
    begin
        #400000;
        error_cnt++;
        print_verdict();
    end
    initial
    begin
        {rstn, psel, penable, pwrite, ctrl_tick, motion_start} = 6'h00;
        {home_done, step, paddr, pwdata, pc_out} = '0;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        t_regs();
        t_decode();
        t_pos();
        t_motion();
        t_home();
        t_freq();
        print_verdict();
    end
endmodule : eips_top_tb
`default_nettype wire
